/* File: design/adc_seq_params.svh */
/*
  Register offsets, field positions, reset values and timing counts of the converter
  control and status block. Assumes inclusion by bare name from design files.
*/
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h20
`define OFS_CHEN 8'h24
`define OFS_CMP0 8'h28
`define OFS_CMP1 8'h2c
`define OFS_STAT 8'h30
`define OFS_RESULT 8'h38

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_FMT 31
`define CTRL_START 11
`define CTRL_DIFF 10
`define CTRL_DMA 9
`define CTRL_EXT_TRIGGER_ENABLE 8
`define CTRL_COND_HI 7
`define CTRL_COND_LO 6
`define CTRL_SRC_HI 5
`define CTRL_SRC_LO 4
`define CTRL_MODE_HI 3
`define CTRL_MODE_LO 2
`define CTRL_IE 1
`define CTRL_PWR 0
`define CTRL_MASK 32'h80000fff

// ----------------------------------------------------------------
// Channel enable and compare fields
// ----------------------------------------------------------------
`define CHEN_MASK 32'h000003ff
`define CMP_MASK 32'h0fff0f3f
`define CMP_DATA_HI 27
`define CMP_DATA_LO 16
`define CMP_CNT_HI 11
`define CMP_CNT_LO 8
`define CMP_CH_HI 5
`define CMP_CH_LO 3
`define CMP_COND 2
`define CMP_IE 1
`define CMP_EN 0

// ----------------------------------------------------------------
// Status fields, encodings and timing
// ----------------------------------------------------------------
`define STAT_BUSY 3
`define STAT_CF1 2
`define STAT_CF0 1
`define STAT_ADF 0
`define SRC_PIN 2'h0
`define TRIG_HOLD_CLKS 4'h8
`define RESET_WORD 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: design/adc_seq_pkg.sv */
/*
  Types of the converter control block. Assumes nothing of its surroundings.
*/
package adc_seq_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_RSVD = 2'h1,
    MODE_SCAN_ONCE = 2'h2,
    MODE_SCAN_CONT = 2'h3
  } op_mode_t;
  typedef enum logic [1:0] {
    TRIG_LOW = 2'h0,
    TRIG_HIGH = 2'h1,
    TRIG_FALL = 2'h2,
    TRIG_RISE = 2'h3
  } trig_cond_t;
endpackage

/* File: design/adc_seq_top.sv */
/*
  Converter control and status logic behind an AXI4-Lite slave: mode, trigger,
  channel enables, compare monitors, status, DMA request and interrupt.
  Assumes a converter core that takes a start pulse with a channel and returns
  a one-cycle done pulse with a 12-bit result.
*/
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module adc_seq_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_trigger_pin,
  output logic conv_start,
  output logic [2:0] conv_channel,
  output logic conv_differential,
  output logic [1:0] ch7_source_select,
  output logic converter_power_enable,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  output logic dma_request,
  output logic converter_irq
);
  logic [31:0] converter_control_reg;
  logic [31:0] channel_enable_reg;
  logic [31:0] compare_monitor_zero;
  logic [31:0] compare_monitor_one;
  logic [7:0] valid_r;
  logic [7:0] overrun_r;
  logic [11:0] last_result_r;
  logic conversion_end_flag;
  logic compare_flag_zero;
  logic compare_flag_one;
  logic [2:0] chan_r;
  logic in_flight_r;
  logic [3:0] trig_cnt_r;
  logic trig_level_r;
  logic trig_stable_r;
  logic trig_prev_r;
  logic trig_armed_r;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  logic rd_go;
  logic [31:0] wmask;
  logic [7:0] chan_mask;
  logic [2:0] next_ch;
  logic last_in_scan;
  logic trig_fire;
  logic conversion_start_bit;
  adc_seq_pkg::op_mode_t mode;
  adc_seq_pkg::trig_cond_t tcond;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expands byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Next enabled channel strictly after cur, wrapping; cur if none other
  function automatic logic [2:0] next_enabled(input logic [7:0] m, input logic [2:0] cur);
    logic [2:0] c;
    next_enabled = cur;
    for (int i = 7; i >= 1; i--) begin
      c = 3'(cur + 3'(i));
      if (m[c]) begin
        next_enabled = c;
      end
    end
  endfunction

  assign mode = adc_seq_pkg::op_mode_t'(converter_control_reg[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  assign tcond = adc_seq_pkg::trig_cond_t'(converter_control_reg[`CTRL_COND_HI:`CTRL_COND_LO]);
  assign conversion_start_bit = converter_control_reg[`CTRL_START];

  // channel enables; odd channels dropped in differential mode
  assign chan_mask = converter_control_reg[`CTRL_DIFF] ?
                     (channel_enable_reg[7:0] & 8'h55) : channel_enable_reg[7:0];
  assign next_ch = next_enabled(chan_mask, chan_r);
  assign last_in_scan = (next_ch <= chan_r);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wmask = strb_mask(w_strb_r);

  // Address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= `RESET_WORD;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_r inside {`OFS_CTRL, `OFS_CHEN, `OFS_CMP0, `OFS_CMP1,
                      `OFS_STAT}) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel; status read is side-effect free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RESET_WORD;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        unique case (s_axi_araddr)
          `OFS_CTRL: s_axi_rdata <= converter_control_reg;
          `OFS_CHEN: s_axi_rdata <= channel_enable_reg;
          `OFS_CMP0: s_axi_rdata <= compare_monitor_zero;
          `OFS_CMP1: s_axi_rdata <= compare_monitor_one;
          `OFS_STAT: s_axi_rdata <= {8'h00, overrun_r, valid_r, 1'b0, chan_r,
                                     conversion_start_bit, compare_flag_one,
                                     compare_flag_zero, conversion_end_flag};
          `OFS_RESULT: s_axi_rdata <= {20'h00000, last_result_r};
          default: begin
            s_axi_rdata <= `RESET_WORD;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Plain read-write words; reserved bits held at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_enable_reg <= `RESET_WORD;
      compare_monitor_zero <= `RESET_WORD;
      compare_monitor_one <= `RESET_WORD;
    end else if (wr_go) begin
      if (aw_addr_r == `OFS_CHEN) begin
        channel_enable_reg <= (channel_enable_reg & ~wmask) | (w_data_r & wmask & `CHEN_MASK);
      end
      if (aw_addr_r == `OFS_CMP0) begin
        compare_monitor_zero <= (compare_monitor_zero & ~wmask) |
                                (w_data_r & wmask & `CMP_MASK);
      end
      if (aw_addr_r == `OFS_CMP1) begin
        compare_monitor_one <= (compare_monitor_one & ~wmask) |
                               (w_data_r & wmask & `CMP_MASK);
      end
    end
  end

  // Control word; start bit also set by trigger, cleared after a single conversion or a one-pass scan
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_control_reg <= `RESET_WORD;
    end else begin
      if (wr_go && aw_addr_r == `OFS_CTRL) begin
        converter_control_reg <= (converter_control_reg & ~wmask) |
                                 (w_data_r & wmask & `CTRL_MASK);
      end
      if (trig_fire) begin
        converter_control_reg[`CTRL_START] <= 1'b1;
      end else if (conv_done && in_flight_r && mode != adc_seq_pkg::MODE_SCAN_CONT &&
                   (mode == adc_seq_pkg::MODE_SINGLE || last_in_scan)) begin
        converter_control_reg[`CTRL_START] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // External trigger
  // ----------------------------------------------------------------
  // level must stand eight clocks before it counts
  // Edge history primed on first settle: an idle-high pin gives no false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_level_r <= 1'b0;
      trig_cnt_r <= 4'h0;
      trig_stable_r <= 1'b0;
      trig_prev_r <= 1'b0;
      trig_armed_r <= 1'b0;
    end else begin
      trig_level_r <= ext_trigger_pin;
      trig_prev_r <= trig_armed_r ? trig_stable_r : trig_level_r;
      if (ext_trigger_pin != trig_level_r) begin
        trig_cnt_r <= 4'h1;
      end else if (trig_cnt_r != `TRIG_HOLD_CLKS) begin
        trig_cnt_r <= trig_cnt_r + 4'h1;
      end else begin
        trig_stable_r <= trig_level_r;
        trig_armed_r <= 1'b1;
      end
    end
  end

  // only enabled, pin source, single-cycle scan, idle
  always_comb begin
    trig_fire = 1'b0;
    if (converter_control_reg[`CTRL_EXT_TRIGGER_ENABLE] && mode == adc_seq_pkg::MODE_SCAN_ONCE &&
        converter_control_reg[`CTRL_SRC_HI:`CTRL_SRC_LO] == `SRC_PIN &&
        !conversion_start_bit && trig_cnt_r == `TRIG_HOLD_CLKS) begin
      unique case (tcond)
        adc_seq_pkg::TRIG_LOW: trig_fire = !trig_level_r;
        adc_seq_pkg::TRIG_HIGH: trig_fire = trig_level_r;
        adc_seq_pkg::TRIG_FALL: trig_fire = trig_armed_r && trig_prev_r && !trig_stable_r;
        adc_seq_pkg::TRIG_RISE: trig_fire = trig_armed_r && !trig_prev_r && trig_stable_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and converter handshake
  // ----------------------------------------------------------------
  // channel pointer; reserved mode never starts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_r <= 3'h0;
      in_flight_r <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (conv_done && in_flight_r) begin
        in_flight_r <= 1'b0;
        if (mode != adc_seq_pkg::MODE_SINGLE) begin
          chan_r <= next_ch;
        end
      end else if (!in_flight_r && !conv_start && conversion_start_bit &&
                   mode != adc_seq_pkg::MODE_RSVD && chan_mask != 8'h00) begin
        if (!chan_mask[chan_r]) begin
          chan_r <= next_ch;
        end else begin
          in_flight_r <= 1'b1;
          conv_start <= 1'b1;
        end
      end else if (!conversion_start_bit && !chan_mask[chan_r] && chan_mask != 8'h00) begin
        chan_r <= next_ch;
      end
    end
  end

  // Converter-facing static controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_channel <= 3'h0;
      conv_differential <= 1'b0;
      ch7_source_select <= 2'h0;
      converter_power_enable <= 1'b0;
    end else begin
      conv_channel <= chan_r;
      conv_differential <= converter_control_reg[`CTRL_DIFF];
      ch7_source_select <= channel_enable_reg[9:8];
      converter_power_enable <= converter_control_reg[`CTRL_PWR];
    end
  end

  // valid and overrun per channel; result lands on the converted channel, the pair's even one in differential mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_r <= 8'h00;
      overrun_r <= 8'h00;
      last_result_r <= 12'h000;
    end else if (conv_done && in_flight_r) begin
      valid_r[chan_r] <= 1'b1;
      overrun_r[chan_r] <= valid_r[chan_r];
      last_result_r <= conv_result;
    end else if (rd_go && s_axi_araddr == `OFS_RESULT) begin
      valid_r <= 8'h00;
      overrun_r <= 8'h00;
    end
  end

  // one request pulse per loaded result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_request <= 1'b0;
    end else begin
      dma_request <= conv_done && in_flight_r && converter_control_reg[`CTRL_DMA];
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  // end flag; set wins over write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_end_flag <= 1'b0;
    end else if (conv_done && in_flight_r &&
                 (mode == adc_seq_pkg::MODE_SINGLE || last_in_scan)) begin
      conversion_end_flag <= 1'b1;
    end else if (wr_go && aw_addr_r == `OFS_STAT && w_strb_r[0] && w_data_r[`STAT_ADF]) begin
      conversion_end_flag <= 1'b0;
    end
  end

  compare_monitor mon_zero (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(compare_monitor_zero),
    .signed_fmt(converter_control_reg[`CTRL_FMT]),
    .load_strobe(conv_done && in_flight_r),
    .load_channel(chan_r),
    .load_value(conv_result),
    .flag_clear(wr_go && aw_addr_r == `OFS_STAT && w_strb_r[0] && w_data_r[`STAT_CF0]),
    .flag(compare_flag_zero)
  );
  compare_monitor mon_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(compare_monitor_one),
    .signed_fmt(converter_control_reg[`CTRL_FMT]),
    .load_strobe(conv_done && in_flight_r),
    .load_channel(chan_r),
    .load_value(conv_result),
    .flag_clear(wr_go && aw_addr_r == `OFS_STAT && w_strb_r[0] && w_data_r[`STAT_CF1]),
    .flag(compare_flag_one)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_irq <= 1'b0;
    end else begin
      converter_irq <= (conversion_end_flag && converter_control_reg[`CTRL_IE]) ||
                       (compare_flag_zero && compare_monitor_zero[`CMP_IE]) ||
                       (compare_flag_one && compare_monitor_one[`CMP_IE]);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_done_with_dma;
    conv_done && in_flight_r && converter_control_reg[`CTRL_DMA];
  endsequence

  a_dma_per_load: assert property (@(posedge aclk) disable iff (!aresetn)
    s_done_with_dma |=> dma_request) else $error("missing dma request");
  a_irq_gating: assert property (@(posedge aclk) disable iff (!aresetn)
    converter_irq |-> $past(conversion_end_flag && converter_control_reg[`CTRL_IE]) ||
      $past(compare_flag_zero && compare_monitor_zero[`CMP_IE]) ||
      $past(compare_flag_one && compare_monitor_one[`CMP_IE])) else $error("irq without cause");
  a_trig_starts: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_fire |=> conversion_start_bit) else $error("trigger did not start");
  a_trig_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_fire |-> $past(trig_level_r, 7) == trig_level_r &&
      $past(trig_level_r) == trig_level_r) else $error("trigger too short");
  a_diff_even: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_start && conv_differential |-> !conv_channel[0]) else $error("odd diff channel");
  a_chan_enabled: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_start |-> channel_enable_reg[conv_channel]) else $error("disabled channel converted");
  a_end_single: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done && in_flight_r && mode == adc_seq_pkg::MODE_SINGLE |=> conversion_end_flag)
    else $error("end flag not set");
  a_irq_compare: assert property (@(posedge aclk) disable iff (!aresetn)
    compare_flag_zero && compare_monitor_zero[`CMP_IE] |=> converter_irq)
    else $error("compare irq missing");
  a_rsvd_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == adc_seq_pkg::MODE_RSVD |-> !conv_start) else $error("reserved mode started");
endmodule

/* File: design/compare_monitor.sv */
/*
  One compare monitor: match counter and sticky flag.
  Assumes result strobes are one-cycle pulses synchronous to aclk.
*/
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module compare_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] cfg,
  input wire logic signed_fmt,
  input wire logic load_strobe,
  input wire logic [2:0] load_channel,
  input wire logic [11:0] load_value,
  input wire logic flag_clear,
  output logic flag
);
  logic [3:0] match_cnt_r;
  logic hit;
  logic sel;
  logic [11:0] ref_val;

  // ----------------------------------------------------------------
  // Compare decision
  // ----------------------------------------------------------------
  // signed or unsigned compare
  always_comb begin
    ref_val = cfg[`CMP_DATA_HI:`CMP_DATA_LO];
    if (signed_fmt) begin
      hit = ($signed(load_value) >= $signed(ref_val)) == cfg[`CMP_COND];
    end else begin
      hit = (load_value >= ref_val) == cfg[`CMP_COND];
    end
  end

  assign sel = cfg[`CMP_EN] && load_strobe &&
               (load_channel == cfg[`CMP_CH_HI:`CMP_CH_LO]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_cnt_r <= 4'h0;
    end else if (sel) begin
      if (!hit) begin
        match_cnt_r <= 4'h0;
      end else if (match_cnt_r != 4'hf) begin
        match_cnt_r <= match_cnt_r + 4'h1;
      end
    end
  end

  // flag at target plus one; set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else if (sel && hit &&
                 ({1'b0, match_cnt_r} + 5'h1 >= {1'b0, cfg[`CMP_CNT_HI:`CMP_CNT_LO]} + 5'h1)) begin
      flag <= 1'b1;
    end else if (flag_clear) begin
      flag <= 1'b0;
    end
  end

  a_miss_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    sel && !hit |=> match_cnt_r == 4'h0) else $error("miss did not clear count");
endmodule

/* File: verification/conv_model.sv */
/*
  Behavioural converter core: answers each start pulse with a one-cycle
  done pulse and a 12-bit result after a fixed delay. Assumes one clock.
*/
`timescale 1ns/1ps

module conv_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_start,
  input wire logic [11:0] value,
  output logic conv_done,
  output logic [11:0] conv_result
);
  logic [3:0] cnt_r;
  logic [11:0] last_r;

  // Fixed three-cycle conversion time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 4'h0;
      conv_done <= 1'b0;
      last_r <= 12'h000;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        cnt_r <= 4'h3;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
        conv_done <= (cnt_r == 4'h1);
        if (cnt_r == 4'h1) begin
          last_r <= value;
        end
      end
    end
  end

  // Result is garbage outside the done cycle, never a stale copy
  assign conv_result = conv_done ? last_r : ~last_r;
endmodule

/* File: verification/testbench.sv */
/*
  Self-checking bench: AXI4-Lite register tasks and conversion sequences.
  Assumes the converter model answers every start pulse.
*/
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module testbench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd_v;
  logic [11:0] res;
  logic [2:0] ch_seen;
  logic [1:0] rsp;
  wire logic awready, wready, bvalid, arready, rvalid, start, done, dma, irq, diff;
  wire logic [1:0] bresp, rresp, src7;
  wire logic [31:0] rdata;
  wire logic [11:0] cres;
  wire logic [2:0] ch;
  int error_cnt, checked, dma_n;
  logic [7:0] regs [5] = '{`OFS_CTRL, `OFS_CHEN, `OFS_CMP0, `OFS_CMP1, `OFS_STAT};

  adc_seq_top adc_seq_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_trigger_pin(trig), .conv_start(start), .conv_channel(ch), .conv_differential(diff),
    .ch7_source_select(src7), .converter_power_enable(), .conv_done(done),
    .conv_result(cres), .dma_request(dma), .converter_irq(irq));
  conv_model conv_model_i (.aclk(aclk), .aresetn(aresetn), .conv_start(start),
    .value(res), .conv_done(done), .conv_result(cres));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Count request pulses; each lasts one cycle. Note the channel of each start
  always @(posedge aclk) begin
    if (dma === 1'b1) dma_n++;
    if (start === 1'b1) ch_seen <= ch;
  end

  task wrap_up;
    begin
      if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    begin
      checked++;
      if (got !== exp) begin
        error_cnt++;
        $display("CHECK FAILED %0t %s", $time, m);
      end
    end
  endtask

  task tmo(input int n);
    begin
      if (n == 100) begin
        error_cnt++;
        wrap_up();
      end
    end
  endtask

  // Each channel is released at the edge that takes it; the answer is taken at its edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
        @(posedge aclk);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
        if (bvalid === 1'b1) break;
      end
      rsp = bresp;
      bready <= 1'b0;
      tmo(n);
    end
  endtask

  task rd(input logic [7:0] a);
    int n;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
        @(posedge aclk);
        if (arready === 1'b1) arvalid <= 1'b0;
        if (rvalid === 1'b1) break;
      end
      rd_v = rdata;
      rsp = rresp;
      rready <= 1'b0;
      tmo(n);
    end
  endtask

  // Poll the busy bit until it reads b
  task poll(input logic b);
    int n;
    begin
      for (n = 0; n < 100; n++) begin
        rd(`OFS_STAT);
        if (rd_v[`STAT_BUSY] === b) break;
      end
      tmo(n);
    end
  endtask

  // Start only from idle, so mode and start are written together safely
  // start from idle
  task conv(input logic [11:0] v, input logic [31:0] c);
    begin
      res <= v;
      wr(`OFS_CTRL, c);
      poll(1'b0);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, trig} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    res = 12'h000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(rd_v, `RESET_WORD, "reset value");
    end
    rd(8'h3c);
    chk(rsp, `RESP_SLVERR, "unmapped read");
    // Band-gap source chosen; the model clock rate is not modelled
    wr(`OFS_CHEN, 32'h00000101);
    rd(`OFS_CHEN);
    chk(rd_v, 32'h00000101, "channel enables");
    chk(src7, 2'h1, "ch7 source");
    wr(`OFS_CMP0, 32'h01000107);
    rd(`OFS_CMP0);
    chk(rd_v, 32'h01000107, "compare zero");
    conv(12'h200, 32'h00000a03);
    rd(`OFS_STAT);
    chk(rd_v & 32'hffffff8f, 32'h00000101, "status one");
    chk(irq, 1, "end irq");
    chk(dma_n, 1, "dma once");
    wr(`OFS_STAT, 32'h1);
    rd(`OFS_STAT);
    chk(irq, 0, "end cleared");
    conv(12'h200, 32'h00000801);
    rd(`OFS_STAT);
    chk(rd_v & 32'hffffff8f, 32'h00010103, "status two");
    chk(irq, 1, "compare irq");
    chk(dma_n, 1, "dma off");
    wr(`OFS_STAT, 32'h3);
    rd(`OFS_STAT);
    chk(rd_v & 32'h7, 32'h0, "flags cleared");
    chk(irq, 0, "irq idle");
    conv(12'h050, 32'h00000801);
    conv(12'h200, 32'h00000801);
    rd(`OFS_STAT);
    chk(rd_v & 32'h2, 32'h0, "miss resets");
    rd(`OFS_RESULT);
    chk(rd_v, 32'h00000200, "last result");
    // Pin-started differential scan of pairs 0 and 1; monitor one on channel 2
    wr(`OFS_STAT, 32'h7);
    wr(`OFS_CHEN, 32'h00000107);
    wr(`OFS_CMP1, 32'h01000013);
    res <= 12'h050;
    wr(`OFS_CTRL, 32'h00000549);
    trig <= 1'b1;
    poll(1'b1);
    trig <= 1'b0;
    poll(1'b0);
    rd(`OFS_STAT);
    chk(rd_v, 32'h00000505, "scan status");
    chk(irq, 1, "compare one irq");
    chk(ch_seen, 3'h2, "last channel");
    chk(diff, 1, "diff out");
    wrap_up();
  end
endmodule
